/* rtl/cfg_word_zero_cfg.svh */
// Constants for the configuration word zero decoder.
// Operation
// R1 - Bit 15 set selects configuration data, clear selects command data.
// R2 - Without saved configuration, start in command mode with error code 6408h.
// R3 - Until valid configuration arrives, motor stays unpowered, motion commands ignored.
// R4 - Bit 14 set disables resonance suppression; clear keeps it active.
// R5 - Bit 13 enables stall detection; only meaningful with an attached encoder.
// R6 - Host programs encoder resolution as four times the line count.
// R7 - Bit 11 lets the network proximity flag take part in homing.
// R8 - Bit 10 enables quadrature encoder; clear means encoder absent.
// R9 - Host writes zero to reserved bit 9.
// R10 - Input three bits 8-6, input two bits 5-3, input one bits 2-0.
// R11 - Codes: general, CW limit, CCW limit, start, stop, e-stop, home, quadrature.
// R12 - General purpose inputs play no motion part but are still reported.
// R13 - With encoder, input three start code latches position on every edge.
// R14 - With encoder, input three stop code latches position on controlled stop.
// R15 - Home on any input with discrete sensors; only input three with encoder.
// R16 - Quadrature only on inputs one (channel A) and two (channel B).
// R17 - Host sets bit 10, both channels quadrature, and word 6 resolution.
// R18 - Quadrature on input three, or encoder without both channels, is invalid.
`ifndef CFG_WORD_ZERO_CFG_SVH
`define CFG_WORD_ZERO_CFG_SVH
`define CW0_MODE_BIT 15
`define CW0_NO_ANTIRES_BIT 14
`define CW0_STALL_BIT 13
`define CW0_PROX_BIT 11
`define CW0_ENC_BIT 10
`define CW0_RSVD_BIT 9
`define CW0_IN3_LSB 6
`define CW0_IN2_LSB 3
`define CW0_IN1_LSB 0
`define CW0_RESET 16'h0000
`define CFG_ERR_CODE 16'h6408
`define NO_ERR_CODE 16'h0000
`endif

/* rtl/cfg_word_zero_pkg.sv */
// Types shared by the configuration word zero decoder.
`default_nettype none
package cfg_word_zero_pkg;
    typedef enum logic [2:0] {
        FN_GENERAL = 3'h0,
        FN_CW_LIMIT = 3'h1,
        FN_CCW_LIMIT = 3'h2,
        FN_START = 3'h3,
        FN_STOP = 3'h4,
        FN_ESTOP = 3'h5,
        FN_HOME = 3'h6,
        FN_QUAD = 3'h7
    } input_fn_t;

    typedef struct packed {
        logic cw_limit;
        logic ccw_limit;
        logic start_move;
        logic stop_move;
        logic estop;
        logic home;
        logic quad;
    } fn_flags_t;

    typedef struct packed {
        logic antires_on;
        logic stall_on;
        logic prox_homing;
        logic encoder_on;
    } feature_t;
endpackage : cfg_word_zero_pkg
`default_nettype wire

/* rtl/input_fn_decode.sv */
// Decoder of one discrete input's function code into motion roles.
`default_nettype none
module input_fn_decode
    import cfg_word_zero_pkg::*;
(
    input wire logic [2:0] code,
    input wire logic level,
    output fn_flags_t roles,
    output logic motion_level
);
    // One-hot role flags from the function code; general purpose sets none.
    assign roles.cw_limit = (code == FN_CW_LIMIT); // R11
    assign roles.ccw_limit = (code == FN_CCW_LIMIT);
    assign roles.start_move = (code == FN_START);
    assign roles.stop_move = (code == FN_STOP);
    assign roles.estop = (code == FN_ESTOP);
    assign roles.home = (code == FN_HOME);
    assign roles.quad = (code == FN_QUAD);
    // A general purpose input never reaches motion logic.
    assign motion_level = level & (code != FN_GENERAL); // R12
endmodule : input_fn_decode
`default_nettype wire

/* rtl/sync2.sv */
// Two-flop synchroniser for the discrete input pins.
`default_nettype none
module sync2 #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : sync2
`default_nettype wire

/* rtl/stepper_config_word_zero_decode.sv */
// Decoder of configuration word zero with input role routing and capture events.
`include "cfg_word_zero_cfg.svh"
`default_nettype none
module stepper_config_word_zero_decode
    import cfg_word_zero_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic word_valid,
    input wire logic [15:0] word_data,
    input wire logic config_saved,
    input wire logic [2:0] input_pins,
    input wire logic motion_cmd,
    output logic [15:0] config_word_zero,
    output logic config_mode,
    output logic config_ok,
    output logic [15:0] error_code,
    output feature_t features,
    output logic motor_power,
    output logic motion_cmd_ok,
    output logic [2:0] input_report,
    output logic cw_limit,
    output logic ccw_limit,
    output logic start_move,
    output logic stop_move,
    output logic estop,
    output logic home,
    output logic enc_a,
    output logic enc_b,
    output logic capture_pulse,
    output logic launch_pulse
);
    logic [2:0] pins_s;
    logic [2:0] pins_d;
    logic [2:0] mlev;
    fn_flags_t r1;
    fn_flags_t r2;
    fn_flags_t r3;
    logic valid_q;
    logic mode_q;
    logic saved_seen;
    logic [15:0] next_word;
    logic next_valid;
    logic [2:0] f1;
    logic [2:0] f2;
    logic [2:0] f3;
    logic wf_enc;
    logic wf_in3_quad;
    logic wf_quad_bad;
    logic wf_home_bad;
    logic word_good;
    logic enc_mode;
    logic in3_edge;
    logic in3_rise;
    logic is_cfg_write;

    sync2 #(.WIDTH(3)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(input_pins),
        .q(pins_s)
    );

    // Field split of the stored word, one function per input.
    assign f1 = config_word_zero[`CW0_IN1_LSB +: 3]; // R10
    assign f2 = config_word_zero[`CW0_IN2_LSB +: 3];
    assign f3 = config_word_zero[`CW0_IN3_LSB +: 3];

    input_fn_decode u_in1 (.code(f1), .level(pins_s[0]), .roles(r1), .motion_level(mlev[0]));
    input_fn_decode u_in2 (.code(f2), .level(pins_s[1]), .roles(r2), .motion_level(mlev[1]));
    input_fn_decode u_in3 (.code(f3), .level(pins_s[2]), .roles(r3), .motion_level(mlev[2]));

    // Validity check of an incoming word; quadrature is legal only on inputs one and two.
    assign wf_enc = word_data[`CW0_ENC_BIT];
    assign wf_in3_quad = (word_data[`CW0_IN3_LSB +: 3] == FN_QUAD); // R18
    assign wf_quad_bad = wf_enc != ((word_data[`CW0_IN1_LSB +: 3] == FN_QUAD)
        && (word_data[`CW0_IN2_LSB +: 3] == FN_QUAD)); // R18 R16
    // With an encoder, home is allowed on input three only.
    assign wf_home_bad = wf_enc && ((word_data[`CW0_IN1_LSB +: 3] == FN_HOME)
        || (word_data[`CW0_IN2_LSB +: 3] == FN_HOME)); // R15
    assign word_good = !wf_in3_quad && !wf_quad_bad && !wf_home_bad;
    assign is_cfg_write = word_valid && word_data[`CW0_MODE_BIT]; // R1

    // A bad configuration word is refused and leaves the device unconfigured.
    // A saved configuration is sampled in the first cycle after reset and counts as valid from the next cycle.
    // A write that lands in that same cycle still decides, so a bad word is never masked.
    always_comb begin
        next_word = config_word_zero;
        next_valid = valid_q || (config_saved && !saved_seen); // R2
        if (is_cfg_write) begin
            if (word_good) begin
                next_word = word_data;
                next_valid = 1'b1;
            end else begin
                next_valid = 1'b0;
            end
        end
    end

    // Stored word and mode; the saved strap is sampled after reset release.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            config_word_zero <= `CW0_RESET;
            valid_q <= 1'b0;
            mode_q <= 1'b0;
            saved_seen <= 1'b0;
        end else begin
            config_word_zero <= next_word;
            valid_q <= next_valid;
            saved_seen <= 1'b1;
            if (word_valid) begin
                mode_q <= word_data[`CW0_MODE_BIT]; // R1
            end
        end
    end

    // Power-up in command mode with a configuration error until valid.
    assign config_mode = mode_q; // R2
    assign config_ok = valid_q;
    assign error_code = valid_q ? `NO_ERR_CODE : `CFG_ERR_CODE; // R2
    assign motor_power = valid_q; // R3
    assign motion_cmd_ok = valid_q && motion_cmd && !mode_q; // R3

    // Feature switches, gated by the configuration being valid.
    assign features.antires_on = valid_q && !config_word_zero[`CW0_NO_ANTIRES_BIT]; // R4
    assign enc_mode = valid_q && config_word_zero[`CW0_ENC_BIT]; // R8
    assign features.encoder_on = enc_mode;
    // Stall detection only counts when the encoder is present.
    assign features.stall_on = enc_mode && config_word_zero[`CW0_STALL_BIT]; // R5
    assign features.prox_homing = valid_q && config_word_zero[`CW0_PROX_BIT]; // R7

    // Inputs are always reported to the host, whatever function they carry.
    assign input_report = pins_s; // R12

    // Motion role outputs, silenced until the configuration is valid.
    assign cw_limit = valid_q && |({r3.cw_limit, r2.cw_limit, r1.cw_limit} & mlev);
    assign ccw_limit = valid_q && |({r3.ccw_limit, r2.ccw_limit, r1.ccw_limit} & mlev);
    assign start_move = valid_q && |({r3.start_move, r2.start_move, r1.start_move} & mlev);
    assign stop_move = valid_q && |({r3.stop_move, r2.stop_move, r1.stop_move} & mlev);
    assign estop = valid_q && |({r3.estop, r2.estop, r1.estop} & mlev);
    // With an encoder input three alone acts as home, the index pulse.
    assign home = valid_q && (enc_mode ? (r3.home & mlev[2])
        : |({r3.home, r2.home, r1.home} & mlev)); // R15
    assign enc_a = enc_mode && r1.quad && pins_s[0]; // R16
    assign enc_b = enc_mode && r2.quad && pins_s[1]; // R16

    // Edge detector on the synchronised input three.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_d <= 3'h0;
        end else begin
            pins_d <= pins_s;
        end
    end
    assign in3_edge = pins_s[2] ^ pins_d[2];
    assign in3_rise = pins_s[2] & !pins_d[2];

    // Capture on any edge for start code, on the stopping edge for stop code.
    // The stop capture uses the rising edge, as that is when the stop is triggered.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            capture_pulse <= 1'b0;
            launch_pulse <= 1'b0;
        end else begin
            capture_pulse <= enc_mode && ((r3.start_move && in3_edge)
                || (r3.stop_move && in3_rise)); // R13 R14
            launch_pulse <= valid_q && r3.start_move && in3_rise; // R13
        end
    end

    // Steps of the input three path that the capture and launch checks are built from.
    sequence s_in3_toggle;
        $changed(pins_s[2]);
    endsequence
    sequence s_in3_rise;
        $rose(pins_s[2]);
    endsequence
    sequence s_in3_fall;
        $fell(pins_s[2]);
    endsequence
    sequence s_launch_once;
        launch_pulse ##1 !launch_pulse;
    endsequence

    // Power-up, validity and mode checks.
    chk_invalid_unpowered: assert property (@(posedge clk) disable iff (!rst_n) // R3
        !config_ok |-> (!motor_power && !motion_cmd_ok && error_code == 16'h6408))
        else $error("motor powered without valid configuration");
    chk_quad_in3_reject: assert property (@(posedge clk) disable iff (!rst_n) // R18
        (is_cfg_write && word_data[8:6] == 3'h7) |=> !config_ok)
        else $error("quadrature on input three accepted");
    chk_mode_follow: assert property (@(posedge clk) disable iff (!rst_n) // R1
        word_valid |=> config_mode == $past(word_data[15]))
        else $error("mode bit not followed");
    chk_saved_start: assert property (@(posedge clk) disable iff (!rst_n) // R2
        (config_saved && !saved_seen && !is_cfg_write) |=> config_ok)
        else $error("saved configuration not taken after reset");
    chk_unsaved_start: assert property (@(posedge clk) disable iff (!rst_n) // R2
        (!config_saved && !saved_seen && !is_cfg_write) |=> !config_ok)
        else $error("unsaved device came up configured");
    chk_power_cmd_mode: assert property (@(posedge clk) disable iff (!rst_n) // R2
        !saved_seen |-> (!config_mode && error_code == 16'h6408))
        else $error("power-up not in command mode with error");
    chk_motion_gate: assert property (@(posedge clk) disable iff (!rst_n) // R3
        motion_cmd_ok |-> (config_ok && !config_mode))
        else $error("motion command passed while not allowed");
    chk_cmd_passes: assert property (@(posedge clk) disable iff (!rst_n) // R3
        (config_ok && !config_mode && motion_cmd) |-> motion_cmd_ok)
        else $error("motion command blocked while configured");
    chk_roles_silent: assert property (@(posedge clk) disable iff (!rst_n) // R3
        !config_ok |-> !(cw_limit || ccw_limit || start_move || stop_move || estop || home))
        else $error("motion role active without configuration");
    chk_launch_needs_cfg: assert property (@(posedge clk) disable iff (!rst_n) // R3
        launch_pulse |-> $past(config_ok))
        else $error("move launched without configuration");
    chk_cmd_write_keeps: assert property (@(posedge clk) disable iff (!rst_n) // R1
        (saved_seen && word_valid && !word_data[15])
        |=> ($stable(config_word_zero) && $stable(config_ok)))
        else $error("command data changed the configuration");
    chk_enc_needs_quad: assert property (@(posedge clk) disable iff (!rst_n) // R18
        (is_cfg_write && word_data[10] && !(word_data[2:0] == 3'h7 && word_data[5:3] == 3'h7))
        |=> !config_ok)
        else $error("encoder accepted without quadrature channels");
    chk_bad_keeps_word: assert property (@(posedge clk) disable iff (!rst_n) // R18
        (is_cfg_write && !word_good) |=> $stable(config_word_zero))
        else $error("refused word was stored");
    chk_no_quad_in3: assert property (@(posedge clk) disable iff (!rst_n) // R18
        config_ok |-> (f3 != 3'h7))
        else $error("valid configuration with quadrature on input three");
    chk_field_store: assert property (@(posedge clk) disable iff (!rst_n) // R10
        (is_cfg_write && word_good) |=> config_word_zero == $past(word_data))
        else $error("good word not stored");

    // Feature switch checks.
    chk_antires_bit: assert property (@(posedge clk) disable iff (!rst_n) // R4
        config_ok |-> features.antires_on == !config_word_zero[14])
        else $error("antiresonance switch wrong");
    chk_features_gated: assert property (@(posedge clk) disable iff (!rst_n) // R4 R8
        !config_ok |-> (features == 4'h0))
        else $error("feature active without configuration");
    chk_stall_needs_enc: assert property (@(posedge clk) disable iff (!rst_n) // R5
        features.stall_on |-> (features.encoder_on && config_word_zero[13]))
        else $error("stall detection without encoder");
    chk_stall_follows: assert property (@(posedge clk) disable iff (!rst_n) // R5
        (features.encoder_on && config_word_zero[13]) |-> features.stall_on)
        else $error("stall detection not enabled");
    chk_prox_bit: assert property (@(posedge clk) disable iff (!rst_n) // R7
        features.prox_homing == (config_ok && config_word_zero[11]))
        else $error("proximity homing switch wrong");
    chk_enc_bit: assert property (@(posedge clk) disable iff (!rst_n) // R8
        features.encoder_on == (config_ok && config_word_zero[10]))
        else $error("encoder switch wrong");
    chk_enc_absent: assert property (@(posedge clk) disable iff (!rst_n) // R8
        !features.encoder_on |-> (!enc_a && !enc_b))
        else $error("encoder activity while absent");
    chk_capture_needs_enc: assert property (@(posedge clk) disable iff (!rst_n) // R8
        capture_pulse |-> $past(features.encoder_on))
        else $error("capture while encoder absent");
    chk_stored_enc_quad: assert property (@(posedge clk) disable iff (!rst_n) // R16 R18
        features.encoder_on |-> (f1 == 3'h7 && f2 == 3'h7 && f3 != 3'h7))
        else $error("encoder on without proper channel inputs");

    // Input role checks.
    chk_code_decode: assert property (@(posedge clk) disable iff (!rst_n) // R11
        (config_ok && f1 == 3'h5 && mlev[0]) |-> estop)
        else $error("emergency stop code not decoded");
    chk_cw_decode: assert property (@(posedge clk) disable iff (!rst_n) // R11
        (config_ok && f2 == 3'h1 && pins_s[1]) |-> cw_limit)
        else $error("clockwise limit code not decoded");
    chk_ccw_decode: assert property (@(posedge clk) disable iff (!rst_n) // R11
        (config_ok && f3 == 3'h2 && pins_s[2]) |-> ccw_limit)
        else $error("counter-clockwise limit code not decoded");
    chk_start_decode: assert property (@(posedge clk) disable iff (!rst_n) // R11
        (config_ok && f1 == 3'h3 && pins_s[0]) |-> start_move)
        else $error("start move code not decoded");
    chk_stop_decode: assert property (@(posedge clk) disable iff (!rst_n) // R11
        (config_ok && f2 == 3'h4 && pins_s[1]) |-> stop_move)
        else $error("stop move code not decoded");
    chk_general_quiet: assert property (@(posedge clk) disable iff (!rst_n) // R12
        (f1 == 3'h0 && f2 == 3'h0 && f3 == 3'h0) |-> !(cw_limit || estop || home))
        else $error("general purpose input drove motion");
    chk_home_encoder: assert property (@(posedge clk) disable iff (!rst_n) // R15
        (enc_mode && home) |-> (r3.home && pins_s[2]))
        else $error("home on wrong input with encoder");
    chk_home_discrete: assert property (@(posedge clk) disable iff (!rst_n) // R15
        (config_ok && !features.encoder_on && f2 == 3'h6 && pins_s[1]) |-> home)
        else $error("home on input two not decoded");
    chk_quad_channels: assert property (@(posedge clk) disable iff (!rst_n) // R16
        enc_a |-> (f1 == 3'h7 && pins_s[0]))
        else $error("channel A not on input one");
    chk_chan_b: assert property (@(posedge clk) disable iff (!rst_n) // R16
        enc_b |-> (f2 == 3'h7 && pins_s[1]))
        else $error("channel B not on input two");
    chk_chan_a_follow: assert property (@(posedge clk) disable iff (!rst_n) // R16
        features.encoder_on |-> (enc_a == pins_s[0]))
        else $error("channel A does not follow input one");
    chk_chan_b_follow: assert property (@(posedge clk) disable iff (!rst_n) // R16
        features.encoder_on |-> (enc_b == pins_s[1]))
        else $error("channel B does not follow input two");

    // Capture and launch checks on input three.
    chk_start_capture: assert property (@(posedge clk) disable iff (!rst_n) // R13
        (enc_mode && r3.start_move && in3_edge) |=> capture_pulse)
        else $error("start edge did not capture");
    chk_stop_capture: assert property (@(posedge clk) disable iff (!rst_n) // R14
        (enc_mode && r3.stop_move && in3_rise) |=> capture_pulse)
        else $error("stop did not capture");
    chk_pin_start_capture: assert property (@(posedge clk) disable iff (!rst_n) // R13
        (features.encoder_on && f3 == 3'h3) ##0 s_in3_toggle |=> capture_pulse)
        else $error("input three transition did not capture");
    chk_pin_stop_capture: assert property (@(posedge clk) disable iff (!rst_n) // R14
        (features.encoder_on && f3 == 3'h4) ##0 s_in3_rise |=> capture_pulse)
        else $error("input three stop did not capture");
    chk_stop_fall_quiet: assert property (@(posedge clk) disable iff (!rst_n) // R14
        (features.encoder_on && f3 == 3'h4) ##0 s_in3_fall |=> !capture_pulse)
        else $error("stop release captured");
    chk_pin_launch: assert property (@(posedge clk) disable iff (!rst_n) // R13
        (config_ok && f3 == 3'h3) ##0 s_in3_rise |=> s_launch_once)
        else $error("activating edge did not launch once");
    chk_no_launch_fall: assert property (@(posedge clk) disable iff (!rst_n) // R13
        (config_ok && f3 == 3'h3) ##0 s_in3_fall |=> !launch_pulse)
        else $error("deactivating edge launched a move");
    chk_capture_cause: assert property (@(posedge clk) disable iff (!rst_n) // R13 R14
        capture_pulse |-> $past(features.encoder_on && (f3 == 3'h3 || f3 == 3'h4)))
        else $error("capture without a capturing input three code");
endmodule : stepper_config_word_zero_decode
`default_nettype wire

/* tb/host_model.sv */
// Host controller model that writes configuration word zero over the cyclic exchange.
`default_nettype none
module host_model (
    input wire logic clk,
    output logic word_valid,
    output logic [15:0] word_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Word six value the host pairs with stall detection: four counts per encoder line.
    localparam int ENC_LINES = 1000;
    localparam logic [15:0] ENC_RESOLUTION = 16'(4 * ENC_LINES);

    // Idle at time zero so the decoder never sees a floating write strobe.
    initial begin
        word_valid = 1'b0;
        word_data = 16'h0000;
    end

    // One write is held from just after an edge to the taking edge.
    // Afterwards the data goes stale and is inverted, so nothing can lean on it.
    task automatic write_word(input logic [15:0] w);
        @(posedge clk);
        #1;
        word_valid = 1'b1;
        word_data = w & 16'hFDFF;
        @(posedge clk);
        #1;
        word_valid = 1'b0;
        word_data = ~w;
    endtask : write_word
endmodule : host_model
`default_nettype wire

/* tb/stepper_config_word_zero_decode_tb.sv */
// Self-checking testbench for the configuration word zero decoder.
`default_nettype none
module stepper_config_word_zero_decode_tb
    import cfg_word_zero_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_n, config_saved, motion_cmd;
    logic [2:0] input_pins;
    wire word_valid;
    wire [15:0] word_data;
    logic [15:0] config_word_zero, error_code;
    logic config_mode, config_ok, motor_power, motion_cmd_ok;
    feature_t features;
    logic [2:0] input_report;
    logic cw_limit, ccw_limit, start_move, stop_move, estop, home, enc_a, enc_b;
    logic capture_pulse, launch_pulse;
    int miscompares, checks;
    logic [15:0] bad[4] = '{16'h81C0, 16'h8407, 16'h843E, 16'h803F};

    host_model host_model_inst (.clk(clk), .word_valid(word_valid), .word_data(word_data));

    stepper_config_word_zero_decode stepper_config_word_zero_decode_inst (
        .clk(clk), .rst_n(rst_n), .word_valid(word_valid), .word_data(word_data),
        .config_saved(config_saved), .input_pins(input_pins), .motion_cmd(motion_cmd),
        .config_word_zero(config_word_zero), .config_mode(config_mode),
        .config_ok(config_ok), .error_code(error_code), .features(features),
        .motor_power(motor_power), .motion_cmd_ok(motion_cmd_ok),
        .input_report(input_report), .cw_limit(cw_limit), .ccw_limit(ccw_limit),
        .start_move(start_move), .stop_move(stop_move), .estop(estop), .home(home),
        .enc_a(enc_a), .enc_b(enc_b), .capture_pulse(capture_pulse),
        .launch_pulse(launch_pulse)
    );

    // Prints the verdict once and ends the run.
    task automatic end_of_test();
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Four-state compare so an unknown never counts as a match.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Moves input three and counts capture and launch pulses over the next six cycles.
    task automatic pin3(input logic v, input logic [3:0] ec, input logic [3:0] el);
        logic [3:0] cap, lau;
        cap = 4'h0;
        lau = 4'h0;
        input_pins[2] = v;
        repeat (6) begin
            @(posedge clk);
            #1;
            cap = cap + {3'h0, capture_pulse};
            lau = lau + {3'h0, launch_pulse};
        end
        chk({12'h0, cap}, {12'h0, ec});
        chk({12'h0, lau}, {12'h0, el});
    endtask : pin3

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // A hang is cut off well beyond the fewer than eighty cycles the tests need.
    initial begin
        #10000;
        miscompares++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        config_saved = 1'b0;
        motion_cmd = 1'b0;
        input_pins = 3'h0;
        miscompares = 0;
        checks = 0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        motion_cmd = 1'b1;
        tick(1);
        chk(error_code, 16'h6408);
        chk({15'h0, config_mode}, 16'h0000);
        chk({14'h0, motor_power, motion_cmd_ok}, 16'h0000);
        host_model_inst.write_word(16'hACFF);
        chk(config_word_zero, 16'hACFF);
        chk({12'h0, features}, 16'h000F);
        chk({13'h0, config_ok, config_mode, motion_cmd_ok}, 16'h0006);
        chk(error_code, 16'h0000);
        pin3(1'b1, 4'h1, 4'h1);
        pin3(1'b0, 4'h1, 4'h0);
        input_pins[0] = 1'b1;
        tick(3);
        chk({14'h0, enc_a, enc_b}, 16'h0002);
        host_model_inst.write_word(16'h0000);
        chk({14'h0, config_mode, motion_cmd_ok}, 16'h0001);
        chk(config_word_zero, 16'hACFF);
        // Each bad word follows a good one, so a refusal must clear the held state.
        foreach (bad[i]) begin
            host_model_inst.write_word(16'hACFF);
            host_model_inst.write_word(bad[i]);
            chk({14'h0, config_ok, motor_power}, 16'h0000);
            chk(config_word_zero, 16'hACFF);
            chk(error_code, 16'h6408);
        end
        // Every discrete code on input one, with suppression off and no encoder.
        for (int c = 0; c < 7; c++) begin
            host_model_inst.write_word(16'hC000 | 16'(c));
            chk({10'h0, cw_limit, ccw_limit, start_move, stop_move, estop, home},
                (c == 0) ? 16'h0000 : (16'h0020 >> (c - 1)));
            chk({13'h0, input_report}, 16'h0001);
            chk({12'h0, features}, 16'h0000);
        end
        host_model_inst.write_word(16'h853F);
        pin3(1'b1, 4'h1, 4'h0);
        pin3(1'b0, 4'h0, 4'h0);
        host_model_inst.write_word(16'h85BF);
        input_pins[2] = 1'b1;
        tick(3);
        chk({14'h0, config_ok, home}, 16'h0003);
        // A mid-run reset with a saved configuration comes up valid in command mode.
        rst_n = 1'b0;
        config_saved = 1'b1;
        tick(2);
        rst_n = 1'b1;
        tick(1);
        chk({13'h0, config_ok, motor_power, motion_cmd_ok}, 16'h0007);
        chk(error_code, 16'h0000);
        chk(config_word_zero, 16'h0000);
        chk({11'h0, config_mode, features}, 16'h0008);
        host_model_inst.write_word(16'h81C0);
        chk({15'h0, config_ok}, 16'h0000);
        end_of_test();
    end
endmodule : stepper_config_word_zero_decode_tb
`default_nettype wire
